// File: src/pdv_pkg.sv
// pdv_pkg: register map, field layout and timing constants of the
// vendor control bank of the pd phy.
// assumes a 100 MHz core clock; used by every file under src/.
package pdv_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] PDV_ADDR_TX_CTRL     = 8'h95;
    localparam logic [7:0] PDV_ADDR_RX_THRESH   = 8'h96;
    localparam logic [7:0] PDV_ADDR_RX_STATUS   = 8'h97;
    localparam logic [7:0] PDV_ADDR_DISCHARGE   = 8'h98;
    localparam logic [7:0] PDV_ADDR_THERMAL     = 8'h99;
    localparam logic [7:0] PDV_ADDR_TIMER_LO    = 8'ha0;
    localparam logic [7:0] PDV_ADDR_TIMER_HI    = 8'ha1;

    localparam logic [7:0] PDV_RESET_VALUE      = 8'h00;
    localparam logic [7:0] PDV_READ_ZERO        = 8'h00;

    // field positions
    localparam int PDV_BIT_CARRIER_CONT   = 2;
    localparam int PDV_BIT_FAST_SWAP      = 1;
    localparam int PDV_BIT_RX_RESERVED    = 3;
    localparam int PDV_BIT_RX_OVERRIDE    = 2;
    localparam int PDV_BIT_RX_SEL_HI      = 1;
    localparam int PDV_BIT_RX_SEL_LO      = 0;
    localparam int PDV_BIT_CABLE_DRAIN    = 1;
    localparam int PDV_BIT_BUS_DRAIN      = 0;
    localparam int PDV_BIT_THERMAL_RAW    = 4;
    localparam int PDV_BIT_THERMAL_ON     = 0;

    // receiver threshold select codes
    typedef enum logic [1:0] {
        PDV_SEL_SINK    = 2'b00,
        PDV_SEL_SOURCE  = 2'b01,
        PDV_SEL_NEUTRAL = 2'b10,
        PDV_SEL_MIXED   = 2'b11
    } pdv_thresh_sel_t;

    // threshold set feeding each bmc comparator
    typedef enum logic [1:0] {
        PDV_LEVEL_SINK    = 2'b00,
        PDV_LEVEL_SOURCE  = 2'b01,
        PDV_LEVEL_NEUTRAL = 2'b10
    } pdv_level_t;

    typedef struct packed {
        pdv_level_t high_level;
        pdv_level_t low_level;
    } pdv_thresh_t;

    // register port request, one cycle per access
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdv_reg_req_t;

    // receiver packet status, bit order as in the status register
    typedef struct packed {
        logic preamble;
        logic crc_ok;
        logic packet_end;
        logic packet_start;
    } pdv_rx_status_t;

    // timing
    localparam int PDV_CLK_MHZ            = 100;
    localparam int PDV_TIMER_STEP_US      = 1000;
    localparam int PDV_TIMER_STEP_CYCLES  = PDV_TIMER_STEP_US * PDV_CLK_MHZ;
    localparam int PDV_BIST_CONT_US       = 45000;
    localparam int PDV_BIST_CONT_CYCLES   = PDV_BIST_CONT_US * PDV_CLK_MHZ;

endpackage : pdv_pkg

// File: src/pdv_slow_timer.sv
// pdv_slow_timer: 16-bit countdown in 1 ms steps with expiry pulse.
// assumes load_in is a one-cycle pulse carrying the combined value.
`timescale 1ns/1ns
`default_nettype none
module pdv_slow_timer #(
    parameter int STEP_CYCLES = pdv_pkg::PDV_TIMER_STEP_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        load_in,
    input  wire logic [15:0] value_in,
    output logic             running_out,
    output logic             expired_out
);

    logic [31:0] step_count;
    logic [15:0] remaining;
    logic        running;

    localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            step_count <= 32'h0;
        else if (load_in || !running || step_count == STEP_LAST)
            step_count <= 32'h0;
        else
            step_count <= step_count + 32'h1;
    end

    // a zero load stops the timer, a non-zero load restarts it
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            remaining <= 16'h0;
            running   <= 1'b0;
        end
        else if (load_in)
        begin
            remaining <= value_in;
            running   <= (value_in != 16'h0);
        end
        else if (running && step_count == STEP_LAST)
        begin
            remaining <= remaining - 16'h1;
            running   <= (remaining != 16'h1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            expired_out <= 1'b0;
        else
            expired_out <= !load_in && running && step_count == STEP_LAST
                           && remaining == 16'h1;
    end

    assign running_out = running;

endmodule : pdv_slow_timer
`default_nettype wire

// File: src/pdv_vendor_regs.sv
// pdv_vendor_regs: vendor control and status bank of the pd phy.
// assumes one register request per cycle from the serial slave and
// receiver/transmitter/analog signals synchronous to clk_in.
//
// Behaviour
// - carrier select 0 timed, 1 continuous
// - fast swap bit sends fast role swap
// - no override: thresholds follow power role
// - override: thresholds from two-bit select
// - four read-only receive status flags
// - cable discharge internal only when bit clear
// - bus discharge internal only when bit clear
// - live thermal flag, enable bit resets off
// - low timer byte held until high write
// - low byte reads last written value
// - count down in 1 ms steps, zero disables
`timescale 1ns/1ns
`default_nettype none
module pdv_vendor_regs #(
    parameter int TIMER_STEP_CYCLES = pdv_pkg::PDV_TIMER_STEP_CYCLES,
    parameter int BIST_CONT_CYCLES  = pdv_pkg::PDV_BIST_CONT_CYCLES
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    // register port
    input  wire pdv_pkg::pdv_reg_req_t   reg_req_in,
    output logic [7:0]                   reg_rdata_out,
    output logic                         reg_rvalid_out,
    // transmitter
    input  wire logic                    bist_carrier_start_in,
    input  wire logic                    bist_carrier_stop_in,
    output logic                         bist_carrier_active_out,
    output logic                         fast_swap_send_out,
    input  wire logic                    fast_swap_sent_in,
    // receiver
    input  wire logic                    power_role_source_in,
    output pdv_pkg::pdv_thresh_t         rx_thresh_out,
    input  wire pdv_pkg::pdv_rx_status_t rx_status_in,
    // power paths
    input  wire logic                    bus_discharge_cond_in,
    input  wire logic                    cable_discharge_cond_in,
    output logic                         bus_drain_on_out,
    output logic                         cable_drain_on_out,
    // thermal
    input  wire logic                    over_temp_detector_in,
    output logic                         over_temp_detector_en_out,
    output logic                         thermal_event_out,
    // slow timer
    output logic                         slow_timer_running_out,
    output logic                         slow_timer_expired_out
);

    // register fields
    logic                     bist_carrier_continuous_sel;
    logic                     fast_swap_send;
    logic                     rx_threshold_spare;
    logic                     rx_threshold_override;
    pdv_pkg::pdv_thresh_sel_t rx_threshold_select;
    pdv_pkg::pdv_rx_status_t  rx_packet_status;
    logic                     cable_power_drain_off;
    logic                     bus_power_drain_off;
    logic                     thermal_sense_on;
    logic                     thermal_raw_flag;
    logic [7:0]               slow_timer_low_value;
    logic [7:0]               slow_timer_high_value;

    // carrier sequencing
    typedef enum logic [1:0] {
        PDV_CARRIER_IDLE  = 2'b00,
        PDV_CARRIER_TIMED = 2'b01,
        PDV_CARRIER_CONT  = 2'b10
    } pdv_carrier_state_t;

    pdv_carrier_state_t carrier_state;
    pdv_carrier_state_t next_carrier_state;
    logic [31:0]        carrier_count;

    localparam logic [31:0] CARRIER_LAST    = 32'(BIST_CONT_CYCLES - 1);
    localparam logic [7:0]  PDV_RESET_VALUE = pdv_pkg::PDV_RESET_VALUE;
    localparam logic [7:0]  PDV_READ_ZERO   = pdv_pkg::PDV_READ_ZERO;

    logic        rd_hit;
    logic        timer_load;
    logic [15:0] timer_value;
    logic [7:0]  next_rdata;

    function automatic logic write_to(input pdv_pkg::pdv_reg_req_t req,
                                      input logic [7:0] addr);
        write_to = req.valid && req.write && req.addr == addr;
    endfunction : write_to

    assign rd_hit = reg_req_in.valid && !reg_req_in.write;

    // transmit control
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            bist_carrier_continuous_sel <= 1'b0;
        else if (write_to(reg_req_in, pdv_pkg::PDV_ADDR_TX_CTRL))
            bist_carrier_continuous_sel <= reg_req_in.wdata[pdv_pkg::PDV_BIT_CARRIER_CONT];
    end

    // set wins over completion so no request is lost
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            fast_swap_send <= 1'b0;
        else if (write_to(reg_req_in, pdv_pkg::PDV_ADDR_TX_CTRL)
                 && reg_req_in.wdata[pdv_pkg::PDV_BIT_FAST_SWAP])
            fast_swap_send <= 1'b1;
        else if (fast_swap_sent_in)
            fast_swap_send <= 1'b0;
    end

    assign fast_swap_send_out = fast_swap_send;

    // select is sampled when the carrier starts
    always_comb
    begin
        next_carrier_state = carrier_state;
        case (carrier_state)
            PDV_CARRIER_IDLE:
                if (bist_carrier_start_in)
                    next_carrier_state = bist_carrier_continuous_sel
                                         ? PDV_CARRIER_CONT
                                         : PDV_CARRIER_TIMED;
            PDV_CARRIER_TIMED:
                if (bist_carrier_stop_in || carrier_count == CARRIER_LAST)
                    next_carrier_state = PDV_CARRIER_IDLE;
            PDV_CARRIER_CONT:
                if (bist_carrier_stop_in)
                    next_carrier_state = PDV_CARRIER_IDLE;
            default:
                next_carrier_state = PDV_CARRIER_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            carrier_state <= PDV_CARRIER_IDLE;
        else
            carrier_state <= next_carrier_state;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            carrier_count <= 32'h0;
        else if (carrier_state == PDV_CARRIER_TIMED)
            carrier_count <= carrier_count + 32'h1;
        else
            carrier_count <= 32'h0;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            bist_carrier_active_out <= 1'b0;
        else
            bist_carrier_active_out <= (next_carrier_state != PDV_CARRIER_IDLE);
    end

    // receive threshold control
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rx_threshold_spare    <= 1'b0;
            rx_threshold_override <= 1'b0;
            rx_threshold_select   <= pdv_pkg::PDV_SEL_SINK;
        end
        else if (write_to(reg_req_in, pdv_pkg::PDV_ADDR_RX_THRESH))
        begin
            rx_threshold_spare    <= reg_req_in.wdata[pdv_pkg::PDV_BIT_RX_RESERVED];
            rx_threshold_override <= reg_req_in.wdata[pdv_pkg::PDV_BIT_RX_OVERRIDE];
            rx_threshold_select   <= pdv_pkg::pdv_thresh_sel_t'(
                reg_req_in.wdata[pdv_pkg::PDV_BIT_RX_SEL_HI:pdv_pkg::PDV_BIT_RX_SEL_LO]);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rx_thresh_out <= '{pdv_pkg::PDV_LEVEL_SINK, pdv_pkg::PDV_LEVEL_SINK};
        else if (!rx_threshold_override)
            rx_thresh_out <= power_role_source_in
                ? '{pdv_pkg::PDV_LEVEL_SOURCE, pdv_pkg::PDV_LEVEL_SOURCE}
                : '{pdv_pkg::PDV_LEVEL_SINK, pdv_pkg::PDV_LEVEL_SINK};
        else
            case (rx_threshold_select)
                pdv_pkg::PDV_SEL_SINK:
                    rx_thresh_out <= '{pdv_pkg::PDV_LEVEL_SINK,
                                       pdv_pkg::PDV_LEVEL_SINK};
                pdv_pkg::PDV_SEL_SOURCE:
                    rx_thresh_out <= '{pdv_pkg::PDV_LEVEL_SOURCE,
                                       pdv_pkg::PDV_LEVEL_SOURCE};
                pdv_pkg::PDV_SEL_NEUTRAL:
                    rx_thresh_out <= '{pdv_pkg::PDV_LEVEL_NEUTRAL,
                                       pdv_pkg::PDV_LEVEL_NEUTRAL};
                default:
                    rx_thresh_out <= '{pdv_pkg::PDV_LEVEL_SINK,
                                       pdv_pkg::PDV_LEVEL_SOURCE};
            endcase
    end

    // receive status follows the receiver; writes have no effect
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rx_packet_status <= '0;
        else
            rx_packet_status <= rx_status_in;
    end

    // discharge paths
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cable_power_drain_off <= 1'b0;
            bus_power_drain_off   <= 1'b0;
        end
        else if (write_to(reg_req_in, pdv_pkg::PDV_ADDR_DISCHARGE))
        begin
            cable_power_drain_off <= reg_req_in.wdata[pdv_pkg::PDV_BIT_CABLE_DRAIN];
            bus_power_drain_off   <= reg_req_in.wdata[pdv_pkg::PDV_BIT_BUS_DRAIN];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cable_drain_on_out <= 1'b0;
            bus_drain_on_out   <= 1'b0;
        end
        else
        begin
            cable_drain_on_out <= cable_discharge_cond_in && !cable_power_drain_off;
            bus_drain_on_out   <= bus_discharge_cond_in && !bus_power_drain_off;
        end
    end

    // thermal sensing
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            thermal_sense_on <= 1'b0;
        else if (write_to(reg_req_in, pdv_pkg::PDV_ADDR_THERMAL))
            thermal_sense_on <= reg_req_in.wdata[pdv_pkg::PDV_BIT_THERMAL_ON];
    end

    // not latched; follows the detector both ways
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            thermal_raw_flag <= 1'b0;
        else
            thermal_raw_flag <= thermal_sense_on && over_temp_detector_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            thermal_event_out <= 1'b0;
        else
            thermal_event_out <= thermal_sense_on && over_temp_detector_in
                                 && !thermal_raw_flag;
    end

    assign over_temp_detector_en_out = thermal_sense_on;

    // slow timer staging
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            slow_timer_low_value <= PDV_RESET_VALUE;
        else if (write_to(reg_req_in, pdv_pkg::PDV_ADDR_TIMER_LO))
            slow_timer_low_value <= reg_req_in.wdata;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            slow_timer_high_value <= PDV_RESET_VALUE;
        else if (write_to(reg_req_in, pdv_pkg::PDV_ADDR_TIMER_HI))
            slow_timer_high_value <= reg_req_in.wdata;
    end

    // the high write applies both bytes at once
    assign timer_load  = write_to(reg_req_in, pdv_pkg::PDV_ADDR_TIMER_HI);
    assign timer_value = {reg_req_in.wdata, slow_timer_low_value};

    pdv_slow_timer #(
        .STEP_CYCLES (TIMER_STEP_CYCLES)
    ) u_slow_timer (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .load_in     (timer_load),
        .value_in    (timer_value),
        .running_out (slow_timer_running_out),
        .expired_out (slow_timer_expired_out)
    );

    // read mux; unmapped offsets read zero
    always_comb
    begin
        next_rdata = PDV_READ_ZERO;
        case (reg_req_in.addr)
            pdv_pkg::PDV_ADDR_TX_CTRL:
            begin
                next_rdata[pdv_pkg::PDV_BIT_CARRIER_CONT] = bist_carrier_continuous_sel;
                next_rdata[pdv_pkg::PDV_BIT_FAST_SWAP]    = fast_swap_send;
            end
            pdv_pkg::PDV_ADDR_RX_THRESH:
            begin
                next_rdata[pdv_pkg::PDV_BIT_RX_RESERVED] = rx_threshold_spare;
                next_rdata[pdv_pkg::PDV_BIT_RX_OVERRIDE] = rx_threshold_override;
                next_rdata[pdv_pkg::PDV_BIT_RX_SEL_HI:pdv_pkg::PDV_BIT_RX_SEL_LO] =
                    rx_threshold_select;
            end
            pdv_pkg::PDV_ADDR_RX_STATUS:
                next_rdata = {4'h0, rx_packet_status};
            pdv_pkg::PDV_ADDR_DISCHARGE:
            begin
                next_rdata[pdv_pkg::PDV_BIT_CABLE_DRAIN] = cable_power_drain_off;
                next_rdata[pdv_pkg::PDV_BIT_BUS_DRAIN]   = bus_power_drain_off;
            end
            pdv_pkg::PDV_ADDR_THERMAL:
            begin
                next_rdata[pdv_pkg::PDV_BIT_THERMAL_RAW] = thermal_raw_flag;
                next_rdata[pdv_pkg::PDV_BIT_THERMAL_ON]  = thermal_sense_on;
            end
            pdv_pkg::PDV_ADDR_TIMER_LO:
                next_rdata = slow_timer_low_value;
            pdv_pkg::PDV_ADDR_TIMER_HI:
                next_rdata = slow_timer_high_value;
            default:
                next_rdata = PDV_READ_ZERO;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out  <= PDV_READ_ZERO;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= rd_hit;
            if (rd_hit)
                reg_rdata_out <= next_rdata;
        end
    end

endmodule : pdv_vendor_regs
`default_nettype wire

// File: verif/pdv_link_model.sv
// pdv_link_model: far-side stand-in for the transmitter and receiver.
// assumes send_in is the fast swap request level.
`timescale 1ns/1ns
`default_nettype none
module pdv_link_model (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               send_in,
    input  wire logic [7:0]         delay_in,
    input  wire logic [3:0]         rx_pat_in,
    output logic                    sent_out,
    output pdv_pkg::pdv_rx_status_t rx_status_out
);
    logic [7:0] wait_cnt;

    assign rx_status_out = rx_pat_in;

    // one sent pulse per request, after delay_in cycles
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sent_out <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else
        begin
            sent_out <= send_in && !sent_out && wait_cnt == delay_in;
            wait_cnt <= (send_in && !sent_out && wait_cnt != delay_in) ? wait_cnt + 8'h01 : 8'h00;
        end
    end
endmodule : pdv_link_model
`default_nettype wire

// File: verif/pdv_vendor_regs_properties.sv
// pdv_regs_checker: port-level properties of the vendor register bank.
// assumes the single clk_in domain with async active-low rst_n_in.
`timescale 1ns/1ns
`default_nettype none
module pdv_regs_checker (
    input wire logic                  clk_in,
    input wire logic                  rst_n_in,
    input wire pdv_pkg::pdv_reg_req_t reg_req_in,
    input wire logic                  reg_rvalid_out,
    input wire logic                  bist_carrier_start_in,
    input wire logic                  bist_carrier_stop_in,
    input wire logic                  bist_carrier_active_out,
    input wire logic                  fast_swap_send_out,
    input wire logic                  fast_swap_sent_in,
    input wire pdv_pkg::pdv_thresh_t  rx_thresh_out,
    input wire logic                  bus_discharge_cond_in,
    input wire logic                  cable_discharge_cond_in,
    input wire logic                  bus_drain_on_out,
    input wire logic                  cable_drain_on_out,
    input wire logic                  over_temp_detector_in,
    input wire logic                  over_temp_detector_en_out,
    input wire logic                  thermal_event_out,
    input wire logic                  slow_timer_running_out,
    input wire logic                  slow_timer_expired_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic swap_wr;
    assign swap_wr = reg_req_in.valid && reg_req_in.write && reg_req_in.addr == 8'h95
        && reg_req_in.wdata[1];

    read_answer_a: assert property (reg_req_in.valid && !reg_req_in.write |=> reg_rvalid_out)
        else $error("read request without answer");
    swap_set_a: assert property (swap_wr |=> fast_swap_send_out)
        else $error("fast swap request not raised");
    swap_clear_a: assert property (fast_swap_sent_in && !swap_wr |=> !fast_swap_send_out)
        else $error("fast swap bit not cleared");
    carrier_start_a: assert property (bist_carrier_start_in && !bist_carrier_active_out
        |=> bist_carrier_active_out)
        else $error("carrier did not start");
    carrier_hold_a: assert property ($rose(bist_carrier_active_out) ##1 !bist_carrier_stop_in[*7]
        |-> bist_carrier_active_out)
        else $error("carrier ended early");
    bus_drain_a: assert property (!bus_discharge_cond_in |=> !bus_drain_on_out)
        else $error("bus drain on without condition");
    cable_drain_a: assert property (!cable_discharge_cond_in |=> !cable_drain_on_out)
        else $error("cable drain on without condition");
    thermal_off_a: assert property (!over_temp_detector_en_out |=> !thermal_event_out)
        else $error("thermal event while disabled");
    thermal_cause_a: assert property (thermal_event_out
        |-> $past(over_temp_detector_in) && $past(over_temp_detector_en_out))
        else $error("thermal event without detector");
    thresh_code_a: assert property (rx_thresh_out.high_level != 2'b11
        && rx_thresh_out.low_level != 2'b11)
        else $error("illegal threshold level");
    timer_expiry_a: assert property (slow_timer_expired_out
        |-> !slow_timer_running_out && $past(slow_timer_running_out))
        else $error("timer expiry without run");

    cover property (swap_wr);
    cover property ($fell(bist_carrier_active_out));
    cover property (thermal_event_out);
    cover property (slow_timer_expired_out);
endmodule : pdv_regs_checker

bind pdv_vendor_regs pdv_regs_checker check_u (.*);
`default_nettype wire

// File: verif/testbench.sv
// testbench: self-checking bench for the vendor register bank.
// assumes short counts: 10-cycle timer step, 20-cycle timed carrier.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_in = 1'b0, rst_n_in = 1'b0, reg_rvalid_out, fast_swap_send_out, fast_swap_sent_in;
    logic bist_carrier_start_in = 1'b0, bist_carrier_stop_in = 1'b0, bist_carrier_active_out;
    logic power_role_source_in = 1'b0, bus_discharge_cond_in = 1'b0, bus_drain_on_out;
    logic cable_discharge_cond_in = 1'b0, cable_drain_on_out, over_temp_detector_in = 1'b0;
    logic over_temp_detector_en_out, thermal_event_out;
    logic slow_timer_running_out, slow_timer_expired_out;
    logic [7:0] reg_rdata_out, delay = 8'h00;
    logic [3:0] rx_pat = 4'h0;
    pdv_pkg::pdv_reg_req_t   reg_req_in = '0;
    pdv_pkg::pdv_thresh_t    rx_thresh_out;
    pdv_pkg::pdv_rx_status_t rx_status_in;
    int error_cnt = 0;
    int checked = 0;

    pdv_vendor_regs #(.TIMER_STEP_CYCLES(10), .BIST_CONT_CYCLES(20)) dut_u (.*);
    pdv_link_model link_u (.clk_in, .rst_n_in, .send_in(fast_swap_send_out), .delay_in(delay),
        .rx_pat_in(rx_pat), .sent_out(fast_swap_sent_in), .rx_status_out(rx_status_in));

    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_req_in <= '{1'b1, 1'b1, a, d};
        @(negedge clk_in);
        reg_req_in <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_in);
        reg_req_in <= '{1'b1, 1'b0, a, 8'h00};
        @(negedge clk_in);
        reg_req_in <= '0;
        chk({7'h00, reg_rvalid_out}, 8'h01);
        chk(reg_rdata_out, e);
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge clk_in);
        s = 1'b1;
        @(negedge clk_in);
        s = 1'b0;
    endtask : pulse

    // bounded wait; running out ends the run as a failure
    task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n >= lim)
        begin
            error_cnt++;
            test_done();
        end
    endtask : wait_for

    task automatic t_regs;
        logic [7:0] a [8] = '{8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'ha0, 8'ha1, 8'h90};
        foreach (a[i]) rd(a[i], 8'h00);
    endtask : t_regs

    task automatic t_swap(input logic [7:0] dl);
        int n;
        delay <= dl;
        wr(8'h95, 8'h02);
        chk({7'h00, fast_swap_send_out}, 8'h01);
        if (dl > 8'h05)
        begin
            wr(8'h95, 8'h00);
            chk({7'h00, fast_swap_send_out}, 8'h01);
        end
        wait_for(fast_swap_send_out, 1'b0, 60, n);
        rd(8'h95, 8'h00);
    endtask : t_swap

    task automatic t_carrier;
        int n;
        wr(8'h95, 8'h00);
        pulse(bist_carrier_start_in);
        wait_for(bist_carrier_active_out, 1'b0, 60, n);
        chk({7'h00, n >= 19 && n <= 21}, 8'h01);
        wr(8'h95, 8'h04);
        pulse(bist_carrier_start_in);
        cyc(40);
        chk({7'h00, bist_carrier_active_out}, 8'h01);
        pulse(bist_carrier_stop_in);
        cyc(1);
        chk({7'h00, bist_carrier_active_out}, 8'h00);
        rd(8'h95, 8'h04);
    endtask : t_carrier

    task automatic t_thresh;
        logic [3:0] e [4] = '{4'h0, 4'h5, 4'ha, 4'h1};
        wr(8'h96, 8'h02);
        power_role_source_in <= 1'b1;
        cyc(2);
        chk({4'h0, rx_thresh_out}, 8'h05);
        power_role_source_in <= 1'b0;
        cyc(2);
        chk({4'h0, rx_thresh_out}, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h96, 8'h04 | s[7:0]);
            cyc(2);
            chk({4'h0, rx_thresh_out}, {4'h0, e[s]});
        end
        wr(8'h96, 8'hff);
        rd(8'h96, 8'h0f);
    endtask : t_thresh

    task automatic t_misc;
        for (int v = 0; v < 16; v += 5)
        begin
            rx_pat <= v[3:0];
            cyc(2);
            rd(8'h97, {4'h0, v[3:0]});
        end
        wr(8'h97, 8'h00);
        rd(8'h97, 8'h0f);
        bus_discharge_cond_in <= 1'b1;
        cable_discharge_cond_in <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h98, c[7:0]);
            cyc(2);
            chk({6'h00, cable_drain_on_out, bus_drain_on_out}, {6'h00, ~c[1:0]});
            rd(8'h98, c[7:0]);
        end
        over_temp_detector_in <= 1'b1;
        cyc(3);
        rd(8'h99, 8'h00);
        wr(8'h99, 8'hff);
        cyc(2);
        rd(8'h99, 8'h11);
        over_temp_detector_in <= 1'b0;
        cyc(2);
        rd(8'h99, 8'h01);
    endtask : t_misc

    task automatic t_timer;
        int n;
        wr(8'ha0, 8'h03);
        cyc(40);
        chk({7'h00, slow_timer_running_out}, 8'h00);
        wr(8'ha1, 8'h00);
        rd(8'ha0, 8'h03);
        wait_for(slow_timer_expired_out, 1'b1, 100, n);
        chk({7'h00, n >= 26 && n <= 30}, 8'h01);
        wr(8'ha0, 8'h05);
        wr(8'ha1, 8'h00);
        cyc(5);
        chk({7'h00, slow_timer_running_out}, 8'h01);
        wr(8'ha0, 8'h00);
        wr(8'ha1, 8'h00);
        cyc(1);
        chk({7'h00, slow_timer_running_out}, 8'h00);
    endtask : t_timer

    initial
    begin
        cyc(2);
        rst_n_in <= 1'b1;
        t_regs();
        t_swap(8'h00);
        t_swap(8'h1e);
        t_carrier();
        t_thresh();
        t_misc();
        t_timer();
        test_done();
    end
endmodule : testbench
`default_nettype wire
